// file: noc_consts.svh
// constants for the nibble core execute block: apb offsets, field positions,
// opcode patterns and reset values; definitions only, included by bare name
`ifndef NOC_CONSTS_SVH
`define NOC_CONSTS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define NOC_OFF_INSTR      8'h00
`define NOC_OFF_REGS       8'h04
`define NOC_OFF_CTRL       8'h08
`define NOC_OFF_RAM        8'h0c

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define NOC_REGS_ACC_LSB   0
`define NOC_REGS_B_LSB     4
`define NOC_REGS_D_LSB     8
`define NOC_REGS_CARRY     12
`define NOC_REGS_SKIP      13
`define NOC_REGS_BUSY      14
`define NOC_REGS_CHAIN     15
`define NOC_CTRL_UPPER     0
`define NOC_CTRL_PTR_LSB   8

// ----------------------------------------------------------------------------
// opcode patterns (10-bit words) and their compare masks
// ----------------------------------------------------------------------------
`define NOC_MASK_NIB       10'h3f0
`define NOC_MASK_PAGE      10'h3c0
`define NOC_MASK_BIT       10'h3fc
`define NOC_MASK_FULL      10'h3ff
`define NOC_OPC_LOAD       10'h070
`define NOC_OPC_TABLE      10'h080
`define NOC_OPC_ADD_MEM    10'h00a
`define NOC_OPC_COMPL      10'h01c
`define NOC_OPC_ROTATE     10'h01d
`define NOC_OPC_SET_BIT    10'h05c
`define NOC_OPC_CLR_BIT    10'h04c
`define NOC_OPC_SKIP_BIT   10'h020
`define NOC_OPC_EQ_MEM     10'h026
`define NOC_OPC_EQ_IMM     10'h025

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define NOC_RST_NIB        4'h0
`define NOC_RST_WORD       10'h000
`define NOC_RST_PTR        6'h00

`endif

// file: noc_pkg.sv
// types shared by the execute core and its nibble alu
// assumes nothing beyond a sv-2012 compiler
package noc_pkg;

  // ----------------------------------------------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------------------------------------------
  typedef enum logic [5:0] {
    noc_st_idle     = 6'h01,  // waiting for a word
    noc_st_exec     = 6'h02,  // one execute cycle
    noc_st_wait2    = 6'h04,  // waiting for the immediate of a compare
    noc_st_tab_push = 6'h08,  // pc pushed, rom addressed
    noc_st_tab_read = 6'h10,  // rom word lands in b and acc, and in d when upper_q is set
    noc_st_tab_pop  = 6'h20   // pc restored
  } noc_state_t;

  // ----------------------------------------------------------------------------
  // alu operations
  // ----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    noc_op_nop, noc_op_load, noc_op_table, noc_op_add_mem, noc_op_complement,
    noc_op_rotate, noc_op_set_bit, noc_op_clear_bit, noc_op_skip_bit_zero,
    noc_op_skip_eq_mem, noc_op_cmp_imm_first, noc_op_cmp_imm_second
  } noc_op_t;

endpackage

// file: noc_alu_if.sv
// carrier between the execute sequencer and the nibble alu
// assumes both ends sit on the same combinational path
`timescale 1ns/1ps
interface noc_alu_if;
  noc_pkg::noc_op_t op;       // operation for this cycle
  logic [3:0]       acc;      // accumulator now
  logic [3:0]       nib;      // ram nibble at the data pointer
  logic             carry;    // carry flag now
  logic [3:0]       imm;      // immediate field
  logic [1:0]       bit_sel;  // selected bit
  logic [3:0]       acc_n;    // new accumulator
  logic [3:0]       nib_n;    // new nibble
  logic             carry_n;  // new carry
  logic             wr_acc;   // accumulator updates
  logic             wr_nib;   // nibble updates
  logic             wr_carry; // carry updates
  logic             skip;     // next word is to be skipped

  modport core (output op, acc, nib, carry, imm, bit_sel,
                input  acc_n, nib_n, carry_n, wr_acc, wr_nib, wr_carry, skip);
  modport alu  (input  op, acc, nib, carry, imm, bit_sel,
                output acc_n, nib_n, carry_n, wr_acc, wr_nib, wr_carry, skip);
endinterface

// file: noc_alu.sv
// combinational nibble alu for the execute core
// assumes the sequencer applies the results at its next clock edge
`timescale 1ns/1ps
module noc_alu (
  // operands and results
  noc_alu_if.alu alu_io
);

  // ----------------------------------------------------------------------------
  // result selection
  // ----------------------------------------------------------------------------
  // defaults keep every result stable so a nop touches nothing
  always_comb begin
    alu_io.acc_n    = alu_io.acc;
    alu_io.nib_n    = alu_io.nib;
    alu_io.carry_n  = alu_io.carry;
    alu_io.wr_acc   = 1'b0;
    alu_io.wr_nib   = 1'b0;
    alu_io.wr_carry = 1'b0;
    alu_io.skip     = 1'b0;
    case (alu_io.op)
      noc_pkg::noc_op_load: begin
        alu_io.acc_n  = alu_io.imm;
        alu_io.wr_acc = 1'b1;
      end
      noc_pkg::noc_op_add_mem: begin
        // sum wraps in four bits, carry left alone
        alu_io.acc_n  = alu_io.acc + alu_io.nib;
        alu_io.wr_acc = 1'b1;
      end
      noc_pkg::noc_op_complement: begin
        alu_io.acc_n  = ~alu_io.acc;
        alu_io.wr_acc = 1'b1;
      end
      noc_pkg::noc_op_rotate: begin
        // five-bit ring: carry into bit 3, bit 0 into carry
        alu_io.acc_n    = {alu_io.carry, alu_io.acc[3:1]};
        alu_io.carry_n  = alu_io.acc[0];
        alu_io.wr_acc   = 1'b1;
        alu_io.wr_carry = 1'b1;
      end
      noc_pkg::noc_op_set_bit: begin
        alu_io.nib_n = alu_io.nib | (4'h1 << alu_io.bit_sel);
        alu_io.wr_nib = 1'b1;
      end
      noc_pkg::noc_op_clear_bit: begin
        alu_io.nib_n = alu_io.nib & ~(4'h1 << alu_io.bit_sel);
        alu_io.wr_nib = 1'b1;
      end
      noc_pkg::noc_op_skip_bit_zero: begin
        alu_io.skip = ~alu_io.nib[alu_io.bit_sel];
      end
      noc_pkg::noc_op_skip_eq_mem: begin
        alu_io.skip = (alu_io.acc == alu_io.nib);
      end
      noc_pkg::noc_op_cmp_imm_second: begin
        alu_io.skip = (alu_io.acc == alu_io.imm);
      end
      default: begin
        alu_io.skip = 1'b0;  // nop, table and first compare word change nothing here
      end
    endcase
  end

endmodule

// file: noc_op_execute.sv
// execute sequencer of a 4-bit core: register file, data ram and apb slave
// assumes a one-cycle synchronous program rom and a stack that honours
// single-cycle push and pop strobes, all on pclk
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "noc_consts.svh"

// Operation
// - load immediate writes operand into accumulator
// - chained immediate loads: only the first acts
// - table read: high bits to b, low to acc
// - upper flag set: bits 9-8 also to d
// - table address: page, d bits, accumulator bits
// - table read pushes and restores pc once
// - add nibble to accumulator, carry kept
// - set selected bit of addressed nibble
// - clear selected bit of addressed nibble
// - skip next when selected bit is zero
// - two-word compare immediate, skip when equal
// - complement inverts the accumulator
// - rotate carry and accumulator right once
module noc_op_execute (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // program rom
  output logic      [12:0] rom_addr,
  output logic             rom_rd,
  input  wire logic [9:0]  rom_data,
  // stack
  output logic             stack_push,
  output logic             stack_pop
);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  noc_pkg::noc_state_t state_q;     // sequencer
  logic [9:0]          instr_q;     // word under execution
  logic [3:0]          acc_q;       // accumulator
  logic [3:0]          b_q;         // register b
  logic [2:0]          d_q;         // register d
  logic                carry_q;     // carry flag
  logic                upper_q;     // upper_table_flag
  logic [5:0]          ptr_q;       // data_pointer
  logic                skip_q;      // next word is skipped
  logic                chain_q;     // last word was an unskipped load
  logic                second_q;    // next word is a compare operand
  logic [3:0]          ram_q [64];  // data ram nibbles
  logic [31:0]         prdata_q;
  logic                pready_q;
  logic                pslverr_q;
  logic [12:0]         rom_addr_q;
  logic                rom_rd_q;
  logic                push_q;
  logic                pop_q;

  noc_alu_if           alu_io ();   // alu carrier
  noc_pkg::noc_op_t    dec_op;      // decoded word
  logic                is_load;     // word matches the load pattern
  logic                can_take;    // writes accepted now
  logic                wr_edge;     // apb write completes this edge
  logic                issue;       // instruction word written
  logic [3:0]          nib;         // addressed_ram_nibble
  logic                in_exec;     // execute cycle

  assign nib     = ram_q[ptr_q];
  assign in_exec = (state_q == noc_pkg::noc_st_exec);
  // writes wait while the core is busy so no two updates share a cycle
  assign can_take = (state_q == noc_pkg::noc_st_idle) || (state_q == noc_pkg::noc_st_wait2);
  assign wr_edge  = psel && penable && pready_q && pwrite && !pslverr_q;
  assign issue    = wr_edge && (paddr == `NOC_OFF_INSTR);

  // ----------------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------------
  // unknown patterns decode to nop
  assign is_load = ((instr_q & `NOC_MASK_NIB) == `NOC_OPC_LOAD);
  always_comb begin
    dec_op = noc_pkg::noc_op_nop;
    if (is_load) begin
      dec_op = noc_pkg::noc_op_load;
    end else if ((instr_q & `NOC_MASK_PAGE) == `NOC_OPC_TABLE) begin
      dec_op = noc_pkg::noc_op_table;
    end else if ((instr_q & `NOC_MASK_BIT) == `NOC_OPC_SET_BIT) begin
      dec_op = noc_pkg::noc_op_set_bit;
    end else if ((instr_q & `NOC_MASK_BIT) == `NOC_OPC_CLR_BIT) begin
      dec_op = noc_pkg::noc_op_clear_bit;
    end else if ((instr_q & `NOC_MASK_BIT) == `NOC_OPC_SKIP_BIT) begin
      dec_op = noc_pkg::noc_op_skip_bit_zero;
    end else if ((instr_q & `NOC_MASK_FULL) == `NOC_OPC_ADD_MEM) begin
      dec_op = noc_pkg::noc_op_add_mem;
    end else if ((instr_q & `NOC_MASK_FULL) == `NOC_OPC_COMPL) begin
      dec_op = noc_pkg::noc_op_complement;
    end else if ((instr_q & `NOC_MASK_FULL) == `NOC_OPC_ROTATE) begin
      dec_op = noc_pkg::noc_op_rotate;
    end else if ((instr_q & `NOC_MASK_FULL) == `NOC_OPC_EQ_MEM) begin
      dec_op = noc_pkg::noc_op_skip_eq_mem;
    end else if ((instr_q & `NOC_MASK_FULL) == `NOC_OPC_EQ_IMM) begin
      dec_op = noc_pkg::noc_op_cmp_imm_first;
    end
  end

  // ----------------------------------------------------------------------------
  // alu hookup
  // ----------------------------------------------------------------------------
  always_comb begin
    if (!in_exec) begin
      alu_io.op = noc_pkg::noc_op_nop;
    end else if (second_q) begin
      alu_io.op = noc_pkg::noc_op_cmp_imm_second;
    end else if (skip_q) begin
      alu_io.op = noc_pkg::noc_op_nop;
    end else if (is_load && chain_q) begin
      alu_io.op = noc_pkg::noc_op_nop;
    end else begin
      alu_io.op = dec_op;
    end
  end
  assign alu_io.acc     = acc_q;
  assign alu_io.nib     = nib;
  assign alu_io.carry   = carry_q;
  assign alu_io.imm     = instr_q[3:0];
  assign alu_io.bit_sel = instr_q[1:0];

  noc_alu u_alu (
    .alu_io (alu_io.alu)
  );

  // ----------------------------------------------------------------------------
  // sequencer and rom/stack strobes
  // ----------------------------------------------------------------------------
  // table read spans push, read and pop: three cycles after execute
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= noc_pkg::noc_st_idle;
      rom_addr_q <= 13'h0000;
      rom_rd_q   <= 1'b0;
      push_q     <= 1'b0;
      pop_q      <= 1'b0;
    end else begin
      rom_rd_q <= 1'b0;
      push_q   <= 1'b0;
      pop_q    <= 1'b0;
      case (state_q)
        noc_pkg::noc_st_idle, noc_pkg::noc_st_wait2: begin
          if (issue) begin
            state_q <= noc_pkg::noc_st_exec;
          end
        end
        noc_pkg::noc_st_exec: begin
          if (alu_io.op == noc_pkg::noc_op_table) begin
            state_q    <= noc_pkg::noc_st_tab_push;
            rom_addr_q <= {instr_q[5:0], d_q, acc_q};
            rom_rd_q   <= 1'b1;
            push_q     <= 1'b1;
          end else if (alu_io.op == noc_pkg::noc_op_cmp_imm_first) begin
            state_q <= noc_pkg::noc_st_wait2;
          end else begin
            state_q <= noc_pkg::noc_st_idle;
          end
        end
        noc_pkg::noc_st_tab_push: begin
          state_q <= noc_pkg::noc_st_tab_read;
        end
        noc_pkg::noc_st_tab_read: begin
          state_q <= noc_pkg::noc_st_tab_pop;
          pop_q   <= 1'b1;
        end
        default: begin
          state_q <= noc_pkg::noc_st_idle;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // word, skip, chain and operand tracking
  // ----------------------------------------------------------------------------
  // a skipped first compare word keeps skip set so its operand is skipped too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q  <= `NOC_RST_WORD;
      skip_q   <= 1'b0;
      chain_q  <= 1'b0;
      second_q <= 1'b0;
    end else begin
      if (issue) begin
        instr_q <= pwdata[9:0];
      end
      if (in_exec) begin
        if (skip_q && !second_q) begin
          skip_q <= (dec_op == noc_pkg::noc_op_cmp_imm_first);
        end else begin
          skip_q <= alu_io.skip;
        end
        chain_q  <= is_load && !second_q && !skip_q;
        second_q <= (alu_io.op == noc_pkg::noc_op_cmp_imm_first);
      end
    end
  end

  // ----------------------------------------------------------------------------
  // core registers
  // ----------------------------------------------------------------------------
  // software writes land only while idle or in wait2, so they never meet an execute update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q   <= `NOC_RST_NIB;
      b_q     <= `NOC_RST_NIB;
      d_q     <= 3'h0;
      carry_q <= 1'b0;
      upper_q <= 1'b0;
      ptr_q   <= `NOC_RST_PTR;
    end else if (state_q == noc_pkg::noc_st_tab_read) begin
      b_q   <= rom_data[7:4];
      acc_q <= rom_data[3:0];
      if (upper_q) begin
        d_q <= {1'b0, rom_data[9:8]};
      end
    end else if (in_exec) begin
      if (alu_io.wr_acc) begin
        acc_q <= alu_io.acc_n;
      end
      if (alu_io.wr_carry) begin
        carry_q <= alu_io.carry_n;
      end
    end else if (wr_edge && paddr == `NOC_OFF_REGS) begin
      acc_q   <= pwdata[`NOC_REGS_ACC_LSB +: 4];
      b_q     <= pwdata[`NOC_REGS_B_LSB +: 4];
      d_q     <= pwdata[`NOC_REGS_D_LSB +: 3];
      carry_q <= pwdata[`NOC_REGS_CARRY];
    end else if (wr_edge && paddr == `NOC_OFF_CTRL) begin
      upper_q <= pwdata[`NOC_CTRL_UPPER];
      ptr_q   <= pwdata[`NOC_CTRL_PTR_LSB +: 6];
    end
  end

  // ----------------------------------------------------------------------------
  // data ram
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 64; i++) begin
        ram_q[i] <= `NOC_RST_NIB;
      end
    end else if (in_exec && alu_io.wr_nib) begin
      ram_q[ptr_q] <= alu_io.nib_n;
    end else if (wr_edge && paddr == `NOC_OFF_RAM) begin
      ram_q[ptr_q] <= pwdata[3:0];
    end
  end

  // ----------------------------------------------------------------------------
  // apb response
  // ----------------------------------------------------------------------------
  // pready rises one cycle into the access phase; writes stall while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (psel && penable && !pready_q && (!pwrite || can_take)) begin
      pready_q  <= 1'b1;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      case (paddr)
        `NOC_OFF_INSTR: prdata_q[9:0] <= instr_q;
        `NOC_OFF_REGS: prdata_q[15:0] <= {chain_q, !can_take, skip_q, carry_q, 1'b0, d_q, b_q, acc_q};
        `NOC_OFF_CTRL: prdata_q[13:0] <= {ptr_q, 7'h00, upper_q};
        `NOC_OFF_RAM: prdata_q[3:0] <= nib;
        default: pslverr_q <= 1'b1;  // unmapped: error, zero data
      endcase
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign rom_addr   = rom_addr_q;
  assign rom_rd     = rom_rd_q;
  assign stack_push = push_q;
  assign stack_pop  = pop_q;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  logic [3:0] sum_now;  // sum the add would produce
  assign sum_now = acc_q + nib;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LOAD_ACC: assert property (alu_io.op == noc_pkg::noc_op_load |=> acc_q == $past(instr_q[3:0]))
    else $error("load did not write accumulator");
  AST_LOAD_CHAIN: assert property (in_exec && !second_q && !skip_q && is_load && chain_q |=> $stable(acc_q))
    else $error("chained load changed accumulator");
  AST_TAB_LOW: assert property (state_q == noc_pkg::noc_st_tab_read |=> b_q == $past(rom_data[7:4]) && acc_q == $past(rom_data[3:0]))
    else $error("table read b or acc wrong");
  AST_TAB_UP: assert property (state_q == noc_pkg::noc_st_tab_read && upper_q |=> d_q == {1'b0, $past(rom_data[9:8])})
    else $error("table read d wrong");
  AST_TAB_ADDR: assert property (push_q |-> rom_addr_q == {instr_q[5:0], d_q, acc_q} && rom_rd_q)
    else $error("table address wrong");
  AST_TAB_STACK: assert property (alu_io.op == noc_pkg::noc_op_table |=> push_q && !pop_q ##1 !push_q && !pop_q ##1 pop_q ##1 !pop_q && state_q == noc_pkg::noc_st_idle)
    else $error("stack push/pop sequence wrong");
  AST_ADD: assert property (alu_io.op == noc_pkg::noc_op_add_mem |=> acc_q == $past(sum_now) && $stable(carry_q))
    else $error("add result or carry wrong");
  AST_SET_BIT: assert property (alu_io.op == noc_pkg::noc_op_set_bit |=> nib[instr_q[1:0]] && state_q == noc_pkg::noc_st_idle)
    else $error("bit not set in one cycle");
  AST_CLR_BIT: assert property (alu_io.op == noc_pkg::noc_op_clear_bit |=> !nib[instr_q[1:0]] && state_q == noc_pkg::noc_st_idle)
    else $error("bit not cleared in one cycle");
  AST_SKIP_BIT: assert property (alu_io.op == noc_pkg::noc_op_skip_bit_zero |=> skip_q == !$past(nib[instr_q[1:0]]))
    else $error("bit test skip wrong");
  AST_CMP_IMM: assert property (alu_io.op == noc_pkg::noc_op_cmp_imm_second |=> skip_q == ($past(acc_q) == $past(instr_q[3:0])))
    else $error("immediate compare skip wrong");
  AST_COMPL: assert property (alu_io.op == noc_pkg::noc_op_complement |=> acc_q == ~$past(acc_q))
    else $error("complement wrong");
  AST_ROTATE: assert property (alu_io.op == noc_pkg::noc_op_rotate |=> {acc_q, carry_q} == {$past(carry_q), $past(acc_q)})
    else $error("rotate wrong");
  AST_CMP_MEM: assert property (alu_io.op == noc_pkg::noc_op_skip_eq_mem |=> skip_q == ($past(acc_q) == $past(nib)))
    else $error("memory compare skip wrong");
  AST_SKIPPED: assert property (in_exec && skip_q && !second_q |=> $stable(acc_q) && $stable(carry_q) && $stable(b_q) && !push_q)
    else $error("skipped word had an effect");

  COV_TABLE: cover property (state_q == noc_pkg::noc_st_tab_read && upper_q);
  COV_CHAIN: cover property (in_exec && is_load && chain_q && !skip_q);
  COV_CMP_HIT: cover property (alu_io.op == noc_pkg::noc_op_cmp_imm_second && alu_io.skip);
  COV_BIT_SKIP: cover property (alu_io.op == noc_pkg::noc_op_skip_bit_zero && alu_io.skip);

endmodule

// file: noc_rom_stack_model.sv
// program rom and stack standing at the far side of the execute core
// assumes a one-cycle synchronous rom and single-cycle push and pop strobes on pclk
`timescale 1ns/1ps
module noc_rom_stack_model (
  // clock
  input  wire logic        pclk,
  // program rom
  input  wire logic [12:0] rom_addr,
  input  wire logic        rom_rd,
  output logic      [9:0]  rom_data,
  // stack
  input  wire logic        stack_push,
  input  wire logic        stack_pop
);
  int depth = 0;  // stack levels in use
  initial rom_data = 10'h000;
  // rom word lands one cycle after the strobe; the page top bits are folded in
  // so a wrong page shows up; outside that cycle the bus toggles, never holds
  always @(posedge pclk) begin
    if (rom_rd) rom_data <= rom_addr[9:0] ^ {rom_addr[12:10], 7'h2b};
    else rom_data <= ~rom_data;
  end
  // one level per table read, popped again afterwards
  always @(posedge pclk) depth <= depth + int'(stack_push) - int'(stack_pop);
endmodule

// file: nibble_core_op_execute_tb.sv
// self-checking bench of the execute core: apb master, queued read checks
// assumes the rom and stack model beside the core
`timescale 1ns/1ps
module nibble_core_op_execute_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rom_rd, stack_push, stack_pop;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [12:0] rom_addr, ad;
  logic [9:0]  rom_data, w;
  logic [31:0] exp_q[$], msk_q[$];  // expected read data and its mask
  logic [5:0]  p, pg;
  logic [3:0]  a, n, s, m;
  logic [2:0]  d;
  logic        c, c2, fl;
  int          fail_count, check_count, seed;
  noc_op_execute u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rom_addr(rom_addr),
    .rom_rd(rom_rd), .rom_data(rom_data), .stack_push(stack_push), .stack_pop(stack_pop));
  noc_rom_stack_model u_rom (.pclk(pclk), .rom_addr(rom_addr), .rom_rd(rom_rd), .rom_data(rom_data),
    .stack_push(stack_push), .stack_pop(stack_pop));
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(logic wr, logic [7:0] ad_i, logic [31:0] wd);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= ad_i; pwdata <= wd; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++t < 50);
    if (t >= 50) fail_count++;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] ad_i, logic [31:0] wd);
    apb(1'b1, ad_i, wd);
  endtask
  // the expectation is noted before the transfer starts
  task automatic rd(logic [7:0] ad_i, logic [31:0] exp, logic [31:0] msk);
    exp_q.push_back(exp); msk_q.push_back(msk);
    apb(1'b0, ad_i, 32'h0);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // clock, read monitor, watchdog
  // ---------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // oldest note is taken off whenever read data is answered
  always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
    check("prdata", prdata & msk_q.pop_front(), exp_q.pop_front());
    check("pslverr", {31'h0, pslverr}, {31'h0, paddr > 8'h0c});
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    end_of_test();
  end
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    seed = 89221; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h04, 32'h0, 32'h1fff);
    wr(8'h00, 32'h075); wr(8'h00, 32'h07a); rd(8'h04, 32'h5, 32'hf);
    wr(8'h00, 32'h3ff); wr(8'h00, 32'h07a); rd(8'h04, 32'ha, 32'hf);
    for (int i = 0; i < 4; i++) begin
      a = 4'($random(seed)); n = 4'($random(seed)); p = 6'($random(seed)); pg = 6'($random(seed));
      d = 3'($random(seed)); c = 1'($random(seed)); fl = i[0];
      wr(8'h08, {18'h0, p, 7'h0, fl}); wr(8'h0c, {28'h0, n}); wr(8'h04, {19'h0, c, 8'h0, a});
      wr(8'h00, 32'h00a); s = a + n; rd(8'h04, {19'h0, c, 8'h0, s}, 32'h100f);
      wr(8'h00, 32'h01d); c2 = s[0]; s = {c, s[3:1]}; c = c2;
      rd(8'h04, {19'h0, c, 8'h0, s}, 32'h100f);
      m = n | (4'h1 << i); wr(8'h00, 32'h05c | i); rd(8'h0c, {28'h0, m}, 32'hf);
      m = n & ~(4'h1 << i); wr(8'h00, 32'h04c | i); rd(8'h0c, {28'h0, m}, 32'hf);
      wr(8'h00, 32'h020 | i); wr(8'h00, 32'h01c); rd(8'h04, {28'h0, s}, 32'hf);
      wr(8'h00, 32'h020 | (i ^ 1)); wr(8'h00, 32'h01c); if (m[i ^ 1]) s = ~s;
      rd(8'h04, {28'h0, s}, 32'hf);
      wr(8'h00, 32'h01c); s = ~s; rd(8'h04, {28'h0, s}, 32'hf);
      s = i[0] ? m : ~m; wr(8'h04, {28'h0, s}); wr(8'h00, 32'h026); wr(8'h00, 32'h01c);
      if (!i[0]) s = ~s;
      rd(8'h04, {28'h0, s}, 32'hf);
      wr(8'h00, 32'h025); wr(8'h00, {28'h007, i[1] ? s : ~s}); wr(8'h00, 32'h01c);
      if (!i[1]) s = ~s;
      rd(8'h04, {28'h0, s}, 32'hf);
      wr(8'h04, {21'h0, d, 4'h0, a}); wr(8'h00, {26'h2, pg}); ad = {pg, d, a};
      wr(8'h08, {18'h0, p, 7'h0, fl});  // reads are answered while busy, a write waits out the table read
      w = ad[9:0] ^ {ad[12:10], 7'h2b};
      rd(8'h04, {21'h0, fl ? {1'b0, w[9:8]} : d, w[7:0]}, 32'h7ff);
      check("rom_addr", {19'h0, rom_addr}, {19'h0, ad});
      check("stack depth", 32'(u_rom.depth), 32'h0);
      $display("test %0d done", i);
    end
    rd(8'h10, 32'h0, 32'hffffffff);
    repeat (4) @(posedge pclk);
    end_of_test();
  end
endmodule
